// ### core/csbh_pkg.sv
package csbh_pkg;

    // ----------------------------------------------------------------
    // Widths and storage
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;               // Character width
    localparam int BUF_DEPTH = 16;           // Transfer buffer entries
    localparam int PTR_W = 4;                // Buffer index width
    localparam int CNT_W = 5;                // Character count width
    localparam int BIT_W = 3;                // Bit position width

    // ----------------------------------------------------------------
    // Named values
    // ----------------------------------------------------------------
    localparam logic [BIT_W-1:0] FIRST_BIT = 3'h0;  // Character start
    localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;   // Eighth bit, MSB first
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;  // Count after reset
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;   // One character left
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;   // Pointer after reset
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00; // Byte after reset
    localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;  // Count decrement
    localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;   // Pointer increment

    // ----------------------------------------------------------------
    // Modes and states
    // ----------------------------------------------------------------
    // Which serial event is dispatched to the handler
    typedef enum logic {EV_EMPTY, EV_END} csbh_timing_t;

    // Stored handler selector, rewritten by each handler except a continuous step that leaves more than one character
    typedef enum logic [2:0] {
        H_START,     // Single character, buffer-empty side
        H_END,       // Single character, transfer-end side
        H_RX_NEXT,   // Continuous reception, more to come
        H_TRX_NEXT,  // Continuous full duplex, more to come
        H_LAST       // Final character of a continuous run
    } csbh_handler_t;

    // Master commands
    typedef enum logic {CMD_MSTR_TX, CMD_TXRX} csbh_cmd_kind_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        csbh_cmd_kind_t kind;     // Continuous reception or full duplex
        logic [PTR_W-1:0] ptr;    // First buffer entry
        logic [CNT_W-1:0] count;  // Characters to move
    } csbh_cmd_t;

    typedef struct packed {
        logic en;                 // Write strobe
        logic [PTR_W-1:0] idx;    // Entry
        logic [DATA_W-1:0] data;  // Value
    } csbh_wr_t;

endpackage

// ### core/csbh_slave_core.sv
// Behaviour
// (RULE_01) Select edge: start serial unit, take command
// (RULE_02) Deselect edge: stop serial unit
// (RULE_03) Deselect: busy high, then release driver
// (RULE_04) Deselect: stop driving serial data out
// (RULE_05) Deselect: buffer-empty timing, transmit and receive on
// (RULE_06) Deselect: initial handler, clear remaining count
// (RULE_07) Start event: busy high, end timing, end handler
// (RULE_08) End event: latch byte, empty timing, start handler
// (RULE_09) Master transmit command: continuous reception
// (RULE_10) Transmit/receive command: continuous full duplex
// (RULE_11) Events dispatched by stored handler selector
// (RULE_12) Type 1 phase, 8 bits, MSB first
// (RULE_13) Last character starting: busy high, last handler
// (RULE_14) Master waits while busy is high
// (RULE_15) Busy low once character serviced
module csbh_slave_core (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link from the master
    input wire logic link_clk,
    input wire logic select_sense_input,
    input wire logic serial_data_in,
    output logic serial_data_out_pin,
    output logic serial_data_out_oe,
    output logic busy_out,
    output logic busy_oe,
    // Command port
    input wire csbh_pkg::csbh_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    // Buffer access
    input wire csbh_pkg::csbh_wr_t buf_wr,
    input wire logic [csbh_pkg::PTR_W-1:0] buf_rd_idx,
    output logic [csbh_pkg::DATA_W-1:0] buf_rd_data,
    input wire logic [csbh_pkg::DATA_W-1:0] single_tx_byte,
    // Status
    output logic serial_unit_channel,
    output logic transfer_event,
    output logic [csbh_pkg::CNT_W-1:0] remaining_char_count,
    output csbh_pkg::csbh_handler_t next_handler_state,
    output logic [csbh_pkg::DATA_W-1:0] rx_holding_byte,
    output logic rx_byte_valid
);

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    logic link_arst;                          // Counter reset
    logic [csbh_pkg::BIT_W-1:0] bit_cnt_reg;  // Bit within character
    logic [csbh_pkg::DATA_W-1:0] rx_shift_reg;  // Incoming bits
    logic [csbh_pkg::DATA_W-1:0] tx_shift_reg;  // Outgoing bits
    logic [csbh_pkg::DATA_W-1:0] rx_word_reg;   // Last whole character
    logic start_tgl_reg;                      // Flips at character start
    logic done_tgl_reg;                       // Flips at character end
    logic [csbh_pkg::DATA_W-1:0] tx_buf_reg;  // Next byte to send

    // Counter held clear while deselected; the link clock may stop
    assign link_arst = rst | select_sense_input;
    // Bit position, 8 bits per character
    always_ff @(posedge link_clk or posedge link_arst) begin
        if (link_arst) begin
            bit_cnt_reg <= csbh_pkg::FIRST_BIT;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;  // see RULE_12
        end
    end
    // Shifting and event toggles; toggles survive deselect on purpose
    // so the system side never sees a false event from a reset
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            rx_shift_reg <= csbh_pkg::BYTE_ZERO;
            {tx_shift_reg, rx_word_reg} <= {2{csbh_pkg::BYTE_ZERO}};
            {start_tgl_reg, done_tgl_reg} <= 2'h0;
        end else if (!select_sense_input) begin
            // Sample on rising edge, MSB first
            rx_shift_reg <= {rx_shift_reg[6:0], serial_data_in};  // see RULE_12
            if (bit_cnt_reg == csbh_pkg::FIRST_BIT) begin
                // Buffer taken: stable because busy held the master
                tx_shift_reg <= {tx_buf_reg[6:0], 1'b0};
                start_tgl_reg <= ~start_tgl_reg;
            end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
            if (bit_cnt_reg == csbh_pkg::LAST_BIT) begin
                rx_word_reg <= {rx_shift_reg[6:0], serial_data_in};
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end
    // MSB must stand before the first edge, hence the buffer tap
    assign serial_data_out_pin = (bit_cnt_reg == csbh_pkg::FIRST_BIT) ?
        tx_buf_reg[7] : tx_shift_reg[7];  // see RULE_12

    // ----------------------------------------------------------------
    // Crossings into the system domain
    // ----------------------------------------------------------------
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;  // Select synchroniser
    logic st_s1_reg, st_s2_reg, st_s3_reg;  // Start toggle synchroniser
    logic dn_s1_reg, dn_s2_reg, dn_s3_reg;  // Done toggle synchroniser
    logic sel_edge;                         // Select line fell
    logic desel_edge;                       // Select line rose
    logic ev_start;                         // Character started
    logic ev_end;                           // Character finished
    // Two flops per crossing, third stage only for edge detection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {cs_s3_reg, cs_s2_reg, cs_s1_reg} <= 3'h7;
            {st_s3_reg, st_s2_reg, st_s1_reg} <= 3'h0;
            {dn_s3_reg, dn_s2_reg, dn_s1_reg} <= 3'h0;
        end else begin
            {cs_s3_reg, cs_s2_reg, cs_s1_reg} <=
                {cs_s2_reg, cs_s1_reg, select_sense_input};
            {st_s3_reg, st_s2_reg, st_s1_reg} <=
                {st_s2_reg, st_s1_reg, start_tgl_reg};
            {dn_s3_reg, dn_s2_reg, dn_s1_reg} <=
                {dn_s2_reg, dn_s1_reg, done_tgl_reg};
        end
    end
    assign sel_edge = cs_s3_reg & ~cs_s2_reg;
    assign desel_edge = ~cs_s3_reg & cs_s2_reg;
    assign ev_start = st_s3_reg ^ st_s2_reg;
    assign ev_end = dn_s3_reg ^ dn_s2_reg;

    // ----------------------------------------------------------------
    // Handler state
    // ----------------------------------------------------------------
    logic run_reg;                          // Serial unit running
    logic so_oe_reg;                        // Data out driven
    logic busy_reg;                         // Busy level
    logic busy_oe_reg;                      // Busy driven
    logic busy_rel_reg;                     // Release pending
    csbh_pkg::csbh_timing_t timing_reg;     // Dispatched event kind
    logic tx_en_reg;                        // Transmit enabled
    logic rx_en_reg;                        // Receive enabled
    csbh_pkg::csbh_handler_t hstate_reg;    // Handler selector
    logic [csbh_pkg::CNT_W-1:0] count_reg;  // Characters left
    logic [csbh_pkg::PTR_W-1:0] ptr_reg;    // Buffer index
    logic [csbh_pkg::DATA_W-1:0] rx_hold_reg;  // Single-mode byte
    logic rx_valid_reg;                     // Byte latched pulse
    logic [csbh_pkg::DATA_W-1:0] buf_mem [csbh_pkg::BUF_DEPTH];
    logic [csbh_pkg::DATA_W-1:0] rd_data_reg;  // Read port
    logic cmd_take;                         // Command accepted
    logic store_rx;                         // Continuous byte store
    // Wrap-around step through the buffer
    function automatic logic [csbh_pkg::PTR_W-1:0] ptr_inc(
        input logic [csbh_pkg::PTR_W-1:0] p);
        ptr_inc = p + csbh_pkg::PTR_STEP;
    endfunction
    // Dispatch only the event kind that the timing selects
    assign transfer_event = run_reg & ~desel_edge &
        ((timing_reg == csbh_pkg::EV_EMPTY) ? (ev_start & tx_en_reg) :
        (ev_end & rx_en_reg));  // see RULE_11
    // Commands only between characters of single mode
    assign cmd_ready = run_reg & ~desel_edge &
        (hstate_reg == csbh_pkg::H_START);
    assign cmd_take = cmd_ready & cmd_valid;
    assign store_rx = transfer_event & (hstate_reg != csbh_pkg::H_START) &
        (hstate_reg != csbh_pkg::H_END);
    // Selection, serial unit run and data-out driver
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (desel_edge) begin
            run_reg <= 1'b0;   // see RULE_02
            so_oe_reg <= 1'b0; // see RULE_04
        end else if (sel_edge) begin
            run_reg <= 1'b1;   // see RULE_01
            so_oe_reg <= 1'b1;
        end
    end
    // Busy driver: high first, released one cycle later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_oe_reg <= 1'b0;
            busy_rel_reg <= 1'b0;
        end else if (desel_edge) begin
            busy_oe_reg <= 1'b1;  // see RULE_03
            busy_rel_reg <= 1'b1;
        end else if (busy_rel_reg) begin
            busy_oe_reg <= 1'b0;  // see RULE_03
            busy_rel_reg <= 1'b0;
        end else if (sel_edge) begin
            busy_oe_reg <= 1'b1;
        end
    end
    // Handler: deselect wins over any event in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_reg <= 1'b1;
            timing_reg <= csbh_pkg::EV_EMPTY;
            {tx_en_reg, rx_en_reg} <= 2'h3;
            hstate_reg <= csbh_pkg::H_START;
            count_reg <= csbh_pkg::CNT_ZERO;
            ptr_reg <= csbh_pkg::PTR_ZERO;
            rx_hold_reg <= csbh_pkg::BYTE_ZERO;
            rx_valid_reg <= 1'b0;
            tx_buf_reg <= csbh_pkg::BYTE_ZERO;
        end else if (desel_edge) begin
            busy_reg <= 1'b1;                   // see RULE_03
            timing_reg <= csbh_pkg::EV_EMPTY;   // see RULE_05
            {tx_en_reg, rx_en_reg} <= 2'h3;     // see RULE_05
            hstate_reg <= csbh_pkg::H_START;    // see RULE_06
            count_reg <= csbh_pkg::CNT_ZERO;    // see RULE_06
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            if (sel_edge) begin
                busy_reg <= 1'b0;  // Ready for the command byte
                tx_buf_reg <= single_tx_byte;
            end
            if (cmd_take) begin
                ptr_reg <= cmd.ptr;
                count_reg <= cmd.count;
                timing_reg <= csbh_pkg::EV_END;
                busy_reg <= 1'b0;
                rx_en_reg <= 1'b1;
                if (cmd.kind == csbh_pkg::CMD_MSTR_TX) begin
                    tx_en_reg <= 1'b0;                  // see RULE_09
                    hstate_reg <= csbh_pkg::H_RX_NEXT;  // see RULE_09
                end else begin
                    tx_en_reg <= 1'b1;                  // see RULE_10
                    tx_buf_reg <= buf_mem[cmd.ptr];     // see RULE_10
                    hstate_reg <= csbh_pkg::H_TRX_NEXT; // see RULE_10
                end
                if (cmd.count == csbh_pkg::CNT_ONE) begin
                    hstate_reg <= csbh_pkg::H_LAST;
                end
            end else if (run_reg && ev_start &&
                    hstate_reg == csbh_pkg::H_LAST) begin
                busy_reg <= 1'b1;  // see RULE_13
            end else if (transfer_event) begin
                case (hstate_reg)  // see RULE_11
                    csbh_pkg::H_START: begin
                        busy_reg <= 1'b1;                 // see RULE_07
                        timing_reg <= csbh_pkg::EV_END;   // see RULE_07
                        hstate_reg <= csbh_pkg::H_END;    // see RULE_07
                    end
                    csbh_pkg::H_END: begin
                        rx_hold_reg <= rx_word_reg;       // see RULE_08
                        rx_valid_reg <= 1'b1;
                        tx_buf_reg <= single_tx_byte;
                        timing_reg <= csbh_pkg::EV_EMPTY; // see RULE_08
                        hstate_reg <= csbh_pkg::H_START;  // see RULE_08
                        busy_reg <= 1'b0;                 // see RULE_15
                    end
                    csbh_pkg::H_RX_NEXT,
                    csbh_pkg::H_TRX_NEXT: begin
                        ptr_reg <= ptr_inc(ptr_reg);           // see RULE_09
                        count_reg <= count_reg - csbh_pkg::CNT_STEP;
                        if (hstate_reg == csbh_pkg::H_TRX_NEXT) begin
                            // Next outgoing byte, see RULE_10
                            tx_buf_reg <= buf_mem[ptr_inc(ptr_reg)];
                        end
                        if (count_reg - csbh_pkg::CNT_STEP ==
                                csbh_pkg::CNT_ONE) begin
                            hstate_reg <= csbh_pkg::H_LAST;  // see RULE_13
                        end
                        busy_reg <= 1'b0;  // see RULE_15
                    end
                    csbh_pkg::H_LAST: begin
                        count_reg <= csbh_pkg::CNT_ZERO;
                        timing_reg <= csbh_pkg::EV_EMPTY;
                        tx_en_reg <= 1'b1;
                        hstate_reg <= csbh_pkg::H_START;
                        tx_buf_reg <= single_tx_byte;
                        busy_reg <= 1'b0;  // see RULE_15
                    end
                    default: begin
                        hstate_reg <= csbh_pkg::H_START;
                    end
                endcase
            end
        end
    end
    // Buffer: link stores take priority over user writes
    always_ff @(posedge ref_clk) begin
        if (store_rx) begin
            buf_mem[ptr_reg] <= rx_word_reg;  // see RULE_09
        end else if (buf_wr.en) begin
            buf_mem[buf_wr.idx] <= buf_wr.data;
        end
    end
    // Registered read port
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_reg <= csbh_pkg::BYTE_ZERO;
        end else begin
            rd_data_reg <= buf_mem[buf_rd_idx];
        end
    end
    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign serial_data_out_oe = so_oe_reg;
    assign busy_out = busy_reg;
    assign busy_oe = busy_oe_reg;
    assign buf_rd_data = rd_data_reg;
    assign serial_unit_channel = run_reg;
    assign remaining_char_count = count_reg;
    assign next_handler_state = hstate_reg;
    assign rx_holding_byte = rx_hold_reg;
    assign rx_byte_valid = rx_valid_reg;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_sel_run: assert property (@(posedge ref_clk) disable iff (rst)
        sel_edge && !desel_edge |=> run_reg)  // see RULE_01
        else $error("unit not started on select");
    chk_desel_stop: assert property (@(posedge ref_clk) disable iff (rst)
        desel_edge |=> !run_reg)  // see RULE_02
        else $error("unit not stopped on deselect");
    chk_busy_release: assert property (@(posedge ref_clk) disable iff (rst)
        desel_edge && !busy_rel_reg |=> busy_reg && busy_oe_reg ##1
        !busy_oe_reg)  // see RULE_03
        else $error("busy not raised then released");
    chk_so_release: assert property (@(posedge ref_clk) disable iff (rst)
        desel_edge |=> !so_oe_reg [*2])  // see RULE_04
        else $error("data out still driven");
    chk_desel_mode: assert property (@(posedge ref_clk) disable iff (rst)
        desel_edge |=> timing_reg == csbh_pkg::EV_EMPTY && tx_en_reg &&
        rx_en_reg)  // see RULE_05
        else $error("idle mode not restored");
    chk_desel_state: assert property (@(posedge ref_clk) disable iff (rst)
        desel_edge |=> hstate_reg == csbh_pkg::H_START &&
        count_reg == csbh_pkg::CNT_ZERO)  // see RULE_06
        else $error("handler not reset on deselect");
    chk_start_step: assert property (@(posedge ref_clk) disable iff (rst)
        transfer_event && hstate_reg == csbh_pkg::H_START && !cmd_take
        |=> busy_reg && timing_reg == csbh_pkg::EV_END &&
        hstate_reg == csbh_pkg::H_END)  // see RULE_07
        else $error("start handler wrong");
    chk_end_latch: assert property (@(posedge ref_clk) disable iff (rst)
        transfer_event && hstate_reg == csbh_pkg::H_END
        |=> rx_hold_reg == $past(rx_word_reg) && !busy_reg &&
        hstate_reg == csbh_pkg::H_START &&
        timing_reg == csbh_pkg::EV_EMPTY)  // see RULE_08
        else $error("end handler wrong");
    chk_cmd_load: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_take |=> count_reg == $past(cmd.count) &&
        ptr_reg == $past(cmd.ptr))  // see RULE_09
        else $error("command not loaded");
    chk_run_step: assert property (@(posedge ref_clk) disable iff (rst)
        transfer_event && hstate_reg == csbh_pkg::H_TRX_NEXT
        |=> ptr_reg == $past(ptr_reg) + 4'h1 &&
        tx_buf_reg == $past(buf_mem[ptr_reg + 4'h1]))  // see RULE_10
        else $error("duplex step wrong");
    chk_last_busy: assert property (@(posedge ref_clk) disable iff (rst)
        run_reg && ev_start && !desel_edge && !cmd_take &&
        hstate_reg == csbh_pkg::H_LAST |=> busy_reg)  // see RULE_13
        else $error("busy not raised on last character");
    chk_char_len: assert property (@(posedge link_clk)
        disable iff (link_arst)
        bit_cnt_reg == csbh_pkg::LAST_BIT |=>
        done_tgl_reg != $past(done_tgl_reg))  // see RULE_12
        else $error("character not eight bits");
    cov_single: cover property (@(posedge ref_clk) disable iff (rst)
        transfer_event && hstate_reg == csbh_pkg::H_END);
    cov_rx_run: cover property (@(posedge ref_clk) disable iff (rst)
        store_rx && hstate_reg == csbh_pkg::H_RX_NEXT);
    cov_trx_last: cover property (@(posedge ref_clk) disable iff (rst)
        transfer_event && hstate_reg == csbh_pkg::H_LAST);
    cov_deselect: cover property (@(posedge ref_clk) disable iff (rst)
        desel_edge ##2 !busy_oe_reg);

endmodule // csbh_slave_core

// ### verification/csbh_master_model.sv
// ----------------------------------------------------------------
// Serial master at the far side of the link
// ----------------------------------------------------------------
module csbh_master_model (
    // Link towards the slave
    output logic link_clk,
    output logic sel_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock stands low outside frames
    initial begin
        link_clk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    // Chip select; data line no longer holds a real value
    task automatic sel(input logic lvl);
        sel_n = lvl;
        sdi = ~sdi;
    endtask
    // One character, 12 ns link clock, slave sampled before each rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        int w;
        w = 0;
        while (busy === 1'b1 && w < 200) begin
            #12 w++;
        end
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #6 rx[i] = sdo;
            link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        sdi = ~tx[0]; // Hold time over, show a changed value
    endtask
endmodule // csbh_master_model

// ### verification/csbh_slave_busy_handshake_tb.sv
module csbh_slave_busy_handshake_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Signals and model state
    // ----------------------------------------------------------------
    logic ref_clk, rst, link_clk, sel_n, sdi, sdo, sdo_oe, busy, busy_oe;
    logic cmd_valid, cmd_ready, run, tev, rxv;
    csbh_pkg::csbh_cmd_t cmd;
    csbh_pkg::csbh_wr_t buf_wr;
    csbh_pkg::csbh_handler_t hs;
    logic [3:0] rd_idx;
    logic [4:0] cnt;
    logic [7:0] rd_data, tx_byte, rx_hold, got, b;
    int mismatches = 0;
    int num_checks = 0;
    int n_ev = 0; // Dispatched events seen
    int n_rxv = 0; // Latched-byte pulses seen
    int mem [16]; // Model of the transfer buffer
    csbh_slave_core dut (
        .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
        .select_sense_input(sel_n), .serial_data_in(sdi),
        .serial_data_out_pin(sdo), .serial_data_out_oe(sdo_oe),
        .busy_out(busy), .busy_oe(busy_oe), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .buf_wr(buf_wr),
        .buf_rd_idx(rd_idx), .buf_rd_data(rd_data),
        .single_tx_byte(tx_byte), .serial_unit_channel(run),
        .transfer_event(tev), .remaining_char_count(cnt),
        .next_handler_state(hs), .rx_holding_byte(rx_hold),
        .rx_byte_valid(rxv));
    csbh_master_model m (.link_clk(link_clk), .sel_n(sel_n), .sdi(sdi),
        .sdo(sdo), .busy(busy));
    // ----------------------------------------------------------------
    // Clock, watchdog and helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Count one-cycle pulses mid-cycle, where they stand settled
    always @(negedge ref_clk) begin
        if (tev === 1'b1) n_ev++;
        if (rxv === 1'b1) n_rxv++;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Settle on a falling edge so sampled outputs are stable
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic issue(csbh_pkg::csbh_cmd_kind_t k, int p, int n);
        @(posedge ref_clk);
        cmd <= '{k, 4'(p), 5'(n)};
        cmd_valid <= 1'b1;
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask
    // Registered read, data one cycle after the index
    task automatic rd(int i);
        @(posedge ref_clk);
        rd_idx <= 4'(i);
        cyc(1);
        chk("buffer", 8'(mem[i]), rd_data);
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hB62E));
        rst = 1'b1;
        {cmd_valid, cmd, buf_wr, rd_idx} = 28'h0000000;
        tx_byte = 8'($urandom);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
        m.sel(1'b0);
        cyc(5);
        chk("run", 8'h01, 8'(run));
        chk("oe", 8'h03, {6'h00, sdo_oe, busy_oe});
        $display("select test done");
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            m.xfer(b, got);
            cyc(6);
            chk("rx hold", b, rx_hold);
            chk("slave data", tx_byte, got);
            chk("busy", 8'h00, 8'(busy));
            chk("state", 8'(csbh_pkg::H_START), 8'(hs));
        end
        chk("valid count", 8'h03, 8'(n_rxv));
        $display("single test done");
        issue(csbh_pkg::CMD_MSTR_TX, 2, 3);
        cyc(1);
        chk("state", 8'(csbh_pkg::H_RX_NEXT), 8'(hs));
        for (int k = 0; k < 3; k++) begin
            mem[2 + k] = int'($urandom) & 8'hFF;
            m.xfer(8'(mem[2 + k]), got);
            cyc(8);
        end
        chk("count", 8'h00, 8'(cnt));
        for (int k = 2; k < 4; k++) rd(k);
        $display("receive run test done");
        for (int k = 8; k < 10; k++) begin
            mem[k] = int'($urandom) & 8'hFF;
            @(posedge ref_clk);
            buf_wr <= '{1'b1, 4'(k), 8'(mem[k])};
            @(posedge ref_clk);
            buf_wr <= '0;
        end
        issue(csbh_pkg::CMD_TXRX, 8, 2);
        cyc(2);
        for (int k = 8; k < 10; k++) begin
            b = 8'($urandom);
            m.xfer(b, got);
            cyc(8);
            chk("duplex out", 8'(mem[k]), got);
            mem[k] = b;
        end
        rd(8);
        chk("event count", 8'h0B, 8'(n_ev));
        $display("duplex test done");
        issue(csbh_pkg::CMD_MSTR_TX, 0, 4);
        m.xfer(8'h5A, got);
        m.sel(1'b1);
        for (int w = 0; w < 20 && run !== 1'b0; w++) @(negedge ref_clk);
        chk("busy drive", 8'h03, {6'h00, busy, busy_oe});
        chk("data oe", 8'h00, 8'(sdo_oe));
        chk("count", 8'h00, 8'(cnt));
        chk("state", 8'(csbh_pkg::H_START), 8'(hs));
        cyc(1);
        chk("busy release", 8'h02, {6'h00, busy, busy_oe});
        chk("run", 8'h00, 8'(run));
        $display("deselect test done");
        test_done();
    end
endmodule // csbh_slave_busy_handshake_tb
